// File: arbiter_defs.vh
`ifndef ARBITER_DEFS_VH
`define ARBITER_DEFS_VH

// machine cycle kinds
`define MC_FETCH      3'h0
`define MC_MEM_READ   3'h1
`define MC_MEM_WRITE  3'h2
`define MC_IDLE       3'h3
`define MC_IO_READ    3'h4

// instruction sequences
`define SEQ_CALL      2'h0
`define SEQ_CALL_SKIP 2'h1
`define SEQ_INC_IDX   2'h2
`define SEQ_IN_PORT   2'h3

// t-states per bus machine cycle
`define T_STATES_BUS  2'h3

// operating modes
`define MODE_NORMAL   2'h0
`define MODE_SLEEP    2'h1
`define MODE_STANDBY  2'h2

`endif

// File: cpu_request_arbiter.v
// Functional notes
// R1: wait sampled only in T2 of bus cycles
// R2: hold, refresh, dma checked each cycle boundary
// R3: interrupts checked only at instruction boundary
// R4: class one before two before three
// R5: hold before refresh before dma
// R6: nmi during dma accepted, dma stops
// R7: nmi after acknowledge completes and service entered
// R8: standby: nmi wakes, peripheral interrupts ignored; nmi is accepted but standby ends only when power_mode changes
// R9: call runs six cycles, pushes high then low
// R10: failed conditional call runs two cycles
// R11: indexed inc/dec runs eight cycles
// R12: port input puts operand low, accumulator high
// R13: reset floats buses; low power drives address high
// R14: idle cycle keeps strobes high, data floating
// R15: ungranted request stays pending for next boundary
// R16: master holds request until grant, then drives
`timescale 1ns/100ps
`include "arbiter_defs.vh"
`default_nettype none

module cpu_request_arbiter (
    // clock, reset, enable
    input  wire        clk,
    input  wire        rst,
    input  wire        ce,
    // external requests (asynchronous pins)
    input  wire        wait_n,
    input  wire        bus_hold_request_n,
    input  wire        nmi_n,
    input  wire        int_n,
    // internal requests (same clock)
    input  wire        refresh_req,
    input  wire        dma_req,
    input  wire        periph_int_req,
    // instruction start
    input  wire        instr_start,
    input  wire [1:0]  instr_kind,
    input  wire        call_cond_ok,
    input  wire [7:0]  operand_m,
    input  wire [7:0]  accumulator,
    input  wire [15:0] pc_addr,
    input  wire [15:0] stack_pointer_reg,
    input  wire [15:0] index_addr,
    input  wire [7:0]  write_data,
    input  wire [1:0]  power_mode,
    // bus pins
    output reg  [15:0] addr_out,
    output reg         addr_oe,
    output reg  [7:0]  data_out,
    output reg         data_oe,
    output reg         rd_strobe_n,
    output reg         wr_strobe_n,
    output reg         memory_request_strobe_n,
    output reg         io_request_strobe_n,
    output reg         opcode_fetch_strobe_n,
    output reg         cycle_status_strobe,
    output reg         bus_hold_grant_n,
    // grants and status
    output reg         refresh_grant,
    output reg         dma_grant,
    output reg         int_ack,
    output reg         nmi_accept,
    output reg         wait_active,
    output wire        seq_busy
);

    // synchronisers for pins
    reg [1:0] wait_sync_reg;
    reg [1:0] hold_sync_reg;
    reg [1:0] nmi_sync_reg;
    reg [1:0] int_sync_reg;
    reg       nmi_prev_reg;
    reg       nmi_pend_reg;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            wait_sync_reg <= 2'h3;
            hold_sync_reg <= 2'h3;
            nmi_sync_reg  <= 2'h3;
            int_sync_reg  <= 2'h3;
        end else if (ce) begin
            wait_sync_reg <= {wait_sync_reg[0], wait_n};
            hold_sync_reg <= {hold_sync_reg[0], bus_hold_request_n};
            nmi_sync_reg  <= {nmi_sync_reg[0], nmi_n};
            int_sync_reg  <= {int_sync_reg[0], int_n};
        end
    end

    wire wait_s = ~wait_sync_reg[1];
    wire hold_s = ~hold_sync_reg[1];
    wire nmi_s  = ~nmi_sync_reg[1];
    wire int_s  = ~int_sync_reg[1];

    // sequencer state
    reg       seq_on_reg;
    reg [1:0] seq_kind_reg;
    reg [2:0] mc_idx_reg;
    reg [1:0] t_reg;
    reg       ack_reg;      // acknowledge cycle running
    reg       ack_done_reg; // service entered, nmi may follow
    reg [1:0] mode_reg;
    reg       dma_on_reg;
    reg       hold_on_reg;

    // machine cycle kind and length for current step
    reg [2:0] mc_kind;
    reg [2:0] seq_len;

    always @* begin
        mc_kind = `MC_IDLE;
        seq_len = 3'd0;
        case (seq_kind_reg)
            `SEQ_CALL: begin
                seq_len = 3'd6; // R9
                case (mc_idx_reg)
                    3'd0:    mc_kind = `MC_FETCH;
                    3'd1:    mc_kind = `MC_MEM_READ;
                    3'd2:    mc_kind = `MC_MEM_READ;
                    3'd3:    mc_kind = `MC_IDLE;
                    default: mc_kind = `MC_MEM_WRITE;
                endcase
            end
            `SEQ_CALL_SKIP: begin
                seq_len = 3'd2; // R10
                mc_kind = (mc_idx_reg == 3'd0) ? `MC_FETCH : `MC_MEM_READ;
            end
            `SEQ_INC_IDX: begin
                seq_len = 3'd0; // eight cycles: wraps 7 -> 0 R11
                case (mc_idx_reg)
                    3'd0:    mc_kind = `MC_FETCH;
                    3'd1:    mc_kind = `MC_FETCH;
                    3'd2:    mc_kind = `MC_MEM_READ;
                    3'd5:    mc_kind = `MC_MEM_READ;
                    3'd7:    mc_kind = `MC_MEM_WRITE;
                    default: mc_kind = `MC_IDLE;
                endcase
            end
            `SEQ_IN_PORT: begin
                seq_len = 3'd3;
                case (mc_idx_reg)
                    3'd0:    mc_kind = `MC_FETCH;
                    3'd1:    mc_kind = `MC_MEM_READ;
                    default: mc_kind = `MC_IO_READ; // R12
                endcase
            end
            default: begin
                seq_len = 3'd0;
                mc_kind = `MC_IDLE;
            end
        endcase
    end

    // idle cycles are one t-state, bus cycles three
    wire       is_idle    = (mc_kind == `MC_IDLE);
    wire [1:0] t_last     = is_idle ? 2'h0 : (`T_STATES_BUS - 2'h1);
    wire       stall      = ~is_idle && (t_reg == 2'h1) && wait_s; // R1
    wire       mc_end     = seq_on_reg && ~hold_on_reg && (t_reg == t_last) && ~stall;
    wire [2:0] mc_next    = mc_idx_reg + 3'd1;
    wire       seq_end    = mc_end && (mc_next == seq_len);
    wire       boundary   = ~seq_on_reg || mc_end;             // R2
    wire       instr_bnd  = ~seq_on_reg;                       // R3
    wire       standby    = (mode_reg == `MODE_STANDBY);
    wire       int_elig   = int_s || (periph_int_req && ~standby); // R8

    assign seq_busy = seq_on_reg | hold_on_reg;

    // arbitration and sequencing
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            seq_on_reg    <= 1'b0;
            seq_kind_reg  <= `SEQ_CALL;
            mc_idx_reg    <= 3'd0;
            t_reg         <= 2'h0;
            ack_reg       <= 1'b0;
            ack_done_reg  <= 1'b0;
            mode_reg      <= `MODE_NORMAL;
            dma_on_reg    <= 1'b0;
            hold_on_reg   <= 1'b0;
            nmi_prev_reg  <= 1'b0;
            nmi_pend_reg  <= 1'b0;
            refresh_grant <= 1'b0;
            dma_grant     <= 1'b0;
            int_ack       <= 1'b0;
            nmi_accept    <= 1'b0;
            wait_active   <= 1'b0;
        end else if (ce) begin
            nmi_prev_reg  <= nmi_s;
            refresh_grant <= 1'b0;
            int_ack       <= 1'b0;
            nmi_accept    <= 1'b0;
            wait_active   <= stall;
            mode_reg      <= power_mode;
            // nmi edge latched until taken
            if (nmi_s && ~nmi_prev_reg)
                nmi_pend_reg <= 1'b1;
            // t-state and machine cycle stepping
            // the sequence pauses while an outside master owns the bus
            if (seq_on_reg && ~stall && ~hold_on_reg) begin
                if (mc_end) begin
                    t_reg      <= 2'h0;
                    mc_idx_reg <= mc_next;
                    if (seq_end || (seq_kind_reg == `SEQ_INC_IDX && mc_next == 3'd0))
                        seq_on_reg <= 1'b0;
                end else begin
                    t_reg <= t_reg + 2'h1;
                end
            end
            // class two at each boundary; unserved stays pending R15
            if (hold_on_reg) begin
                hold_on_reg <= hold_s; // R16
            end else if (boundary) begin
                if (hold_s) begin
                    hold_on_reg <= 1'b1;   // R5
                    dma_on_reg  <= 1'b0;
                end else if (refresh_req) begin
                    refresh_grant <= 1'b1; // R5
                end else if (dma_req && ~nmi_pend_reg) begin
                    dma_on_reg <= 1'b1;    // R5
                end else begin
                    dma_on_reg <= 1'b0;
                end
            end
            // nmi stops dma at once R6
            if (nmi_pend_reg && dma_on_reg)
                dma_on_reg <= 1'b0;
            // class three only at instruction boundary, after class two R4
            if (instr_bnd && ~hold_on_reg && ~hold_s && ~refresh_req && ~dma_on_reg) begin
                if (ack_reg) begin
                    ack_reg      <= 1'b0;  // R7
                    ack_done_reg <= 1'b1;
                    int_ack      <= 1'b1;
                end else if (nmi_pend_reg) begin
                    nmi_pend_reg <= nmi_s & ~nmi_prev_reg; // a fresh edge wins over the clear
                    nmi_accept   <= 1'b1;                  // R8
                    ack_done_reg <= 1'b0;                  // standby is left through power_mode
                end else if (int_elig) begin
                    ack_reg <= 1'b1;       // R3
                end else if (instr_start) begin
                    ack_done_reg <= 1'b0;
                    seq_on_reg   <= 1'b1;
                    mc_idx_reg   <= 3'd0;
                    t_reg        <= 2'h0;
                    seq_kind_reg <= (instr_kind == `SEQ_CALL && ~call_cond_ok) ?
                                    `SEQ_CALL_SKIP : instr_kind;
                end
            end
            dma_grant <= dma_on_reg;
        end
    end

    // bus pin drive
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            addr_out                <= 16'h0000;
            addr_oe                 <= 1'b0;    // R13
            data_out                <= 8'h00;
            data_oe                 <= 1'b0;
            rd_strobe_n             <= 1'b1;
            wr_strobe_n             <= 1'b1;
            memory_request_strobe_n <= 1'b1;
            io_request_strobe_n     <= 1'b1;
            opcode_fetch_strobe_n   <= 1'b1;
            cycle_status_strobe     <= 1'b1;    // R13
            bus_hold_grant_n        <= 1'b1;    // R13
        end else if (ce) begin
            bus_hold_grant_n        <= ~hold_on_reg;
            rd_strobe_n             <= 1'b1;    // R14
            wr_strobe_n             <= 1'b1;
            memory_request_strobe_n <= 1'b1;
            io_request_strobe_n     <= 1'b1;
            opcode_fetch_strobe_n   <= 1'b1;
            data_oe                 <= 1'b0;
            addr_oe                 <= ~hold_on_reg;
            cycle_status_strobe     <= 1'b1;
            if (mode_reg != `MODE_NORMAL) begin
                addr_out <= 16'hFFFF;           // R13
                addr_oe  <= 1'b1;
            end else if (seq_on_reg && ~hold_on_reg && ~is_idle && (t_reg != 2'h0)) begin
                // strobes rest high in the first t-state so each bus cycle opens with a fall
                case (mc_kind)
                    `MC_FETCH: begin
                        addr_out                <= pc_addr;
                        rd_strobe_n             <= 1'b0;
                        memory_request_strobe_n <= 1'b0;
                        opcode_fetch_strobe_n   <= 1'b0;
                        cycle_status_strobe     <= (mc_idx_reg != 3'd0); // R11
                    end
                    `MC_MEM_READ: begin
                        addr_out                <= (seq_kind_reg == `SEQ_INC_IDX && mc_idx_reg == 3'd5) ?
                                                   index_addr : pc_addr;
                        rd_strobe_n             <= 1'b0;
                        memory_request_strobe_n <= 1'b0; // R10
                    end
                    `MC_MEM_WRITE: begin
                        wr_strobe_n             <= 1'b0;
                        memory_request_strobe_n <= 1'b0;
                        data_oe                 <= 1'b1;
                        data_out                <= write_data;
                        addr_out                <= index_addr;
                        if (seq_kind_reg == `SEQ_CALL) begin
                            addr_out <= stack_pointer_reg - {13'h0000, (mc_idx_reg == 3'd4) ? 3'd1 : 3'd2}; // R9
                            data_out <= (mc_idx_reg == 3'd4) ? pc_addr[15:8] : pc_addr[7:0];
                        end
                    end
                    `MC_IO_READ: begin
                        addr_out            <= {accumulator, operand_m}; // R12
                        rd_strobe_n         <= 1'b0;
                        io_request_strobe_n <= 1'b0;
                    end
                    default: begin
                        addr_out <= addr_out;
                    end
                endcase
            end
        end
    end

endmodule

`default_nettype wire

// File: arb_chk_sva.sv
`timescale 1ns/100ps
`default_nettype none
module arb_chk (
    // clock and reset
    input wire logic        clk,
    input wire logic        rst,
    // watched inputs
    input wire logic [1:0]  power_mode,
    input wire logic        int_n,
    input wire logic [7:0]  operand_m,
    input wire logic [7:0]  accumulator,
    // bus pins and grants
    input wire logic [15:0] addr_out,
    input wire logic        addr_oe,
    input wire logic        data_oe,
    input wire logic        rd_strobe_n,
    input wire logic        wr_strobe_n,
    input wire logic        memory_request_strobe_n,
    input wire logic        io_request_strobe_n,
    input wire logic        opcode_fetch_strobe_n,
    input wire logic        cycle_status_strobe,
    input wire logic        bus_hold_grant_n,
    input wire logic        refresh_grant,
    input wire logic        dma_grant,
    input wire logic        int_ack,
    input wire logic        nmi_accept
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // pin states and strobe pairings per machine cycle
    chk_reset_float: assert property (
        disable iff (1'b0) rst && $past(rst) |-> !addr_oe && !data_oe && bus_hold_grant_n && cycle_status_strobe)
        else $error("bus driven in reset");
    chk_port_read: assert property (
        !io_request_strobe_n && opcode_fetch_strobe_n |->
        memory_request_strobe_n && addr_out == {accumulator, operand_m})
        else $error("bad port read cycle");
    chk_fetch_read: assert property (
        !opcode_fetch_strobe_n && io_request_strobe_n |-> !rd_strobe_n && !memory_request_strobe_n)
        else $error("bad fetch strobes");
    chk_write_mem: assert property (
        !wr_strobe_n |-> data_oe && rd_strobe_n && !memory_request_strobe_n)
        else $error("bad write strobes");
    chk_hold_float: assert property (
        !bus_hold_grant_n |-> !addr_oe && !data_oe && !refresh_grant && !dma_grant)
        else $error("bus not released");
    chk_standby_mask: assert property (
        (power_mode == 2'h2 && int_n) [*4] |-> !int_ack)
        else $error("interrupt taken in standby");
    chk_nmi_dma: assert property (
        nmi_accept && $past(dma_grant) |-> ##[0:2] !dma_grant)
        else $error("dma kept after nmi");
    chk_sleep_addr: assert property (
        (power_mode == 2'h1) [*3] |-> addr_oe && addr_out == 16'hffff && !data_oe)
        else $error("bad sleep pins");
endmodule
bind cpu_request_arbiter arb_chk arb_chk_inst (.clk(clk), .rst(rst), .power_mode(power_mode), .int_n(int_n),
    .operand_m(operand_m), .accumulator(accumulator), .addr_out(addr_out), .addr_oe(addr_oe),
    .data_oe(data_oe), .rd_strobe_n(rd_strobe_n), .wr_strobe_n(wr_strobe_n),
    .memory_request_strobe_n(memory_request_strobe_n), .io_request_strobe_n(io_request_strobe_n),
    .opcode_fetch_strobe_n(opcode_fetch_strobe_n), .cycle_status_strobe(cycle_status_strobe),
    .bus_hold_grant_n(bus_hold_grant_n), .refresh_grant(refresh_grant), .dma_grant(dma_grant),
    .int_ack(int_ack), .nmi_accept(nmi_accept));
`default_nettype wire

// File: bus_partner.sv
`timescale 1ns/100ps
`default_nettype none
module bus_partner (
    // clock
    input wire logic  clk,
    // device side
    input wire logic  memory_request_strobe_n,
    input wire logic  io_request_strobe_n,
    input wire logic  bus_hold_grant_n,
    // test controls
    input wire logic  slow,
    input wire logic  want_bus,
    // request pins
    output var logic  wait_n = 1'b1,
    output var logic  bus_hold_request_n = 1'b1
);
    int wcnt = 0;
    int hcnt = 0;
    // slow memory stretches each cycle by pulling wait low
    always @(posedge clk) begin
        if (slow && ($fell(memory_request_strobe_n) || $fell(io_request_strobe_n))) begin
            wcnt <= 8;
        end else if (wcnt > 0) begin
            wcnt <= wcnt - 1;
        end
        wait_n <= (wcnt == 0);
    end
    // outside master holds its request until granted, then uses the bus briefly
    always @(posedge clk) begin
        if (!want_bus) begin
            bus_hold_request_n <= 1'b1;
            hcnt <= 0;
        end else if (hcnt == 0 && bus_hold_request_n) begin
            bus_hold_request_n <= 1'b0;
        end else if (!bus_hold_request_n && !bus_hold_grant_n) begin
            hcnt <= hcnt + 1;
            if (hcnt == 4) bus_hold_request_n <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// File: cpu_request_arbiter_bus_cycles_tb.sv
`timescale 1ns/100ps
`default_nettype none
module cpu_request_arbiter_bus_cycles_tb;
    typedef struct {logic [1:0] k; logic c; int f, r, w, io;} row_t;
    // sequence kind, condition, then expected fetch, read, write and port cycles
    row_t        rows [4] = '{'{2'h0, 1'b1, 1, 2, 2, 0}, '{2'h0, 1'b0, 1, 1, 0, 0},
                              '{2'h2, 1'b1, 2, 2, 1, 0}, '{2'h3, 1'b1, 1, 1, 0, 1}};
    logic        clk = 1'b0, rst = 1'b1, start = 1'b0, cond = 1'b0, ref_req = 1'b0, dma_req = 1'b0;
    logic        pint = 1'b0, nmi_n = 1'b1, int_n = 1'b1, slow = 1'b0, want = 1'b0;
    logic [1:0]  kind = 2'h0, pmode = 2'h0;
    logic [7:0]  opnd = 8'h5a, acc = 8'ha7, wdat = 8'h3c;
    logic [15:0] pc = 16'h1234, sp = 16'h8000, ix = 16'h4010;
    wire         wait_n, hold_n, aoe, doe, rd_n, wr_n, memory_request_strobe_n_n, io_request_strobe_n_n, m1_n, st, gnt_n, rgnt, dgnt;
    wire         iack, nacc, wact, busy;
    wire [15:0]  addr;
    wire [7:0]   dout;
    int          n_mismatch = 0, checked = 0, cyc = 0, nf = 0, nr = 0, nw = 0, nio = 0;
    int          wseen = 0, nseen = 0, aseen = 0, ack_w = 0;
    logic [15:0] wa [4];
    logic [7:0]  wd [4];
    int          ev [$];

    cpu_request_arbiter cpu_request_arbiter_inst (.clk(clk), .rst(rst), .ce(1'b1), .wait_n(wait_n),
        .bus_hold_request_n(hold_n), .nmi_n(nmi_n), .int_n(int_n), .refresh_req(ref_req), .dma_req(dma_req),
        .periph_int_req(pint), .instr_start(start), .instr_kind(kind), .call_cond_ok(cond), .operand_m(opnd),
        .accumulator(acc), .pc_addr(pc), .stack_pointer_reg(sp), .index_addr(ix), .write_data(wdat),
        .power_mode(pmode), .addr_out(addr), .addr_oe(aoe), .data_out(dout), .data_oe(doe), .rd_strobe_n(rd_n),
        .wr_strobe_n(wr_n), .memory_request_strobe_n(memory_request_strobe_n_n), .io_request_strobe_n(io_request_strobe_n_n),
        .opcode_fetch_strobe_n(m1_n), .cycle_status_strobe(st), .bus_hold_grant_n(gnt_n),
        .refresh_grant(rgnt), .dma_grant(dgnt), .int_ack(iack), .nmi_accept(nacc), .wait_active(wact),
        .seq_busy(busy));
    bus_partner bus_partner_inst (.clk(clk), .memory_request_strobe_n(memory_request_strobe_n_n), .io_request_strobe_n(io_request_strobe_n_n),
        .bus_hold_grant_n(gnt_n), .slow(slow), .want_bus(want), .wait_n(wait_n), .bus_hold_request_n(hold_n));

    // clock
    initial forever #4 clk = ~clk;

    // count bus cycles, log grants and cut a hang short
    always @(posedge clk) begin
        cyc++;
        if ($fell(memory_request_strobe_n_n) && !m1_n) nf++;
        if ($fell(memory_request_strobe_n_n) && m1_n && !rd_n) nr++;
        if ($fell(io_request_strobe_n_n) && m1_n) nio++;
        if ($fell(wr_n)) begin
            wa[nw % 4] = addr;
            wd[nw % 4] = dout;
            nw++;
        end
        if (wact === 1'b1) wseen = 1;
        if (nacc === 1'b1) nseen = 1;
        if (iack === 1'b1) begin
            aseen = 1;
            ack_w = nw;
        end
        if ($fell(gnt_n)) ev.push_back(1);
        if (rgnt === 1'b1) ev.push_back(2);
        if ($rose(dgnt)) ev.push_back(3);
        if (cyc == 20000) begin
            n_mismatch++;
            end_sim();
        end
    end

    task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
        checked++;
        if (s !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic run(input logic [1:0] k, input logic c);
        int t;
        nf = 0;
        nr = 0;
        nw = 0;
        nio = 0;
        t = 0;
        @(negedge clk);
        kind = k;
        cond = c;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        while ((busy !== 1'b0 || t < 2) && t < 400) begin
            @(negedge clk);
            t++;
        end
        repeat (4) @(negedge clk);
    endtask

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (2) @(posedge clk);
        #1;
        chk("reset addr oe", {15'h0, aoe}, 16'h0000);
        chk("reset grant", {15'h0, gnt_n}, 16'h0001);
        chk("reset status", {15'h0, st}, 16'h0001);
        @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        $display("test reset done");
        foreach (rows[i]) begin
            pc = pc + 16'h0111;
            sp = sp - 16'h0020;
            run(rows[i].k, rows[i].c);
            chk("fetches", 16'(nf), 16'(rows[i].f));
            chk("reads", 16'(nr), 16'(rows[i].r));
            chk("writes", 16'(nw), 16'(rows[i].w));
            chk("port reads", 16'(nio), 16'(rows[i].io));
            if (rows[i].k == 2'h0 && rows[i].c) begin
                chk("push hi addr", wa[0], sp - 16'h0001);
                chk("push hi data", {8'h00, wd[0]}, {8'h00, pc[15:8]});
                chk("push lo addr", wa[1], sp - 16'h0002);
                chk("push lo data", {8'h00, wd[1]}, {8'h00, pc[7:0]});
            end
            if (rows[i].k == 2'h2) chk("index write", wa[0], ix);
        end
        $display("test table done");
        ev.delete();
        slow = 1'b1;
        fork
            run(2'h0, 1'b1);
            begin
                @(negedge memory_request_strobe_n_n);
                @(negedge clk);
                want = 1'b1;
                // let the hold pin clear its synchroniser so all three meet at one boundary
                repeat (3) @(negedge clk);
                ref_req = 1'b1;
                dma_req = 1'b1;
                wait (rgnt === 1'b1);
                @(negedge clk);
                ref_req = 1'b0;
                wait (dgnt === 1'b1);
                @(negedge clk);
                dma_req = 1'b0;
            end
        join
        want = 1'b0;
        slow = 1'b0;
        chk("wait seen", 16'(wseen), 16'h0001);
        chk("call after grants", 16'(nw), 16'h0002);
        chk("first grant", 16'(ev[0]), 16'h0001);
        chk("second grant", 16'(ev[1]), 16'h0002);
        chk("third grant", 16'(ev[2]), 16'h0003);
        $display("test priority done");
        dma_req = 1'b1;
        wait (dgnt === 1'b1);
        @(negedge clk);
        nmi_n = 1'b0;
        // dma request stays up, so only the nmi can stop the grant
        while (nacc !== 1'b1) @(negedge clk);
        chk("dma stopped", {15'h0, dgnt}, 16'h0000);
        nmi_n = 1'b1;
        dma_req = 1'b0;
        repeat (10) @(negedge clk);
        chk("nmi in dma", 16'(nseen), 16'h0001);
        $display("test nmi dma done");
        fork
            run(2'h0, 1'b1);
            begin
                repeat (3) @(negedge clk);
                int_n = 1'b0;
            end
        join
        repeat (20) @(negedge clk);
        int_n = 1'b1;
        // let the released pin pass the synchroniser and the last acknowledge finish
        repeat (6) @(negedge clk);
        chk("int acked", 16'(aseen), 16'h0001);
        chk("int after pushes", 16'(ack_w), 16'h0002);
        $display("test interrupt done");
        aseen = 0;
        nseen = 0;
        pmode = 2'h2;
        // the mode is registered, so standby must be in force before the request
        repeat (2) @(negedge clk);
        pint = 1'b1;
        repeat (30) @(negedge clk);
        chk("standby masks", 16'(aseen), 16'h0000);
        nmi_n = 1'b0;
        repeat (3) @(negedge clk);
        nmi_n = 1'b1;
        repeat (10) @(negedge clk);
        chk("standby nmi", 16'(nseen), 16'h0001);
        pmode = 2'h0;
        repeat (20) @(negedge clk);
        pint = 1'b0;
        chk("normal takes int", 16'(aseen), 16'h0001);
        $display("test standby done");
        pmode = 2'h1;
        repeat (6) @(negedge clk);
        chk("sleep addr", addr, 16'hffff);
        chk("sleep data float", {15'h0, doe}, 16'h0000);
        pmode = 2'h0;
        repeat (6) @(negedge clk);
        $display("test sleep done");
        end_sim();
    end
endmodule
`default_nettype wire
